// *** core/stepper_pkg.sv ***
package stepper_pkg;

  // --------------------------------------------------------------
  // sequencer geometry
  // --------------------------------------------------------------
  localparam int POS_W = 5; // 32 eighth steps per electrical cycle
  localparam logic [4:0] INIT_POS = 5'h00; // A phase at full peak
  localparam logic [4:0] INC_FULL = 5'h08;
  localparam logic [4:0] INC_HALF = 5'h04;
  localparam logic [4:0] INC_QUARTER = 5'h02;
  localparam logic [4:0] INC_EIGHTH = 5'h01;

  // --------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int CTRL_KILL_BIT = 0; // software bridge disable
  localparam logic CTRL_KILL_RST = 1'b0;
  localparam int ST_POS_LSB = 0;
  localparam int ST_RES_LSB = 5;
  localparam int ST_MO_BIT = 7;
  localparam int ST_OP_LSB = 8;
  localparam int ST_BRIDGE_BIT = 10;
  localparam int ST_CHOP_BIT = 11;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    RES_FULL = 2'b00,
    RES_HALF = 2'b01,
    RES_QUARTER = 2'b10,
    RES_EIGHTH = 2'b11
  } res_e;

  typedef enum logic [1:0] {
    OP_LOW_POWER_HOLD_N = 2'b00,
    OP_WAIT = 2'b01,
    OP_INIT = 2'b10,
    OP_RUN = 2'b11
  } op_e;

  // host control pins and protection flags, carried together
  typedef struct packed {
    logic step;
    logic dir;
    logic rst_n;
    logic en;
    logic hold_n;
    logic [1:0] sel;
    logic thermal;
    logic uv;
  } pins_s;

endpackage

// *** core/stepper_microstep_control.sv ***
`timescale 1ns/1ns
module stepper_microstep_control
  import stepper_pkg::*;
#(
  parameter int AW = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host control pins
  input wire logic step_clock_in_i,
  input wire logic direction_select_i,
  input wire logic seq_reset_n_i,
  input wire logic enable_i,
  input wire logic low_power_hold_n_i,
  input wire logic excitation_sel_0_i,
  input wire logic excitation_sel_1_i,
  // protection flags and oscillator
  input wire logic thermal_trip_i,
  input wire logic supply_undervolt_lock_i,
  input wire logic osc_clock_i,
  // bridge and sequencer state
  output logic bridge_drive_en_o,
  output logic [POS_W-1:0] seq_position_o,
  output logic chopper_clk_o,
  // open-drain monitor pin
  input wire logic step_monitor_in_i,
  output logic step_monitor_out_o,
  output logic step_monitor_oe_n_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pins_s s1;
    pins_s s2;
    logic step_prev;
    logic osc1;
    logic osc2;
    logic osc_prev;
    logic chop;
    logic [POS_W-1:0] pos;
    logic bridge;
    logic kill;
    logic ack;
    logic [31:0] rdata;
  } state_s;

  state_s r_reg;
  state_s r_next;
  pins_s pins;
  op_e op;
  logic step_rise;
  logic osc_rise;
  logic [POS_W-1:0] inc;
  logic mo_drive;
  logic [31:0] status;

  // step size for the selected resolution
  function automatic logic [POS_W-1:0] step_inc(input res_e res);
    case (res)
      RES_FULL: step_inc = INC_FULL;
      RES_HALF: step_inc = INC_HALF;
      RES_QUARTER: step_inc = INC_QUARTER;
      RES_EIGHTH: step_inc = INC_EIGHTH;
      default: step_inc = INC_EIGHTH;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // decode of synchronised pins
  // ----------------------------------------------------------------
  // only the second stage is looked at, never the first
  always_comb begin
    pins = '{step: step_clock_in_i, dir: direction_select_i, rst_n: seq_reset_n_i,
             en: enable_i, hold_n: low_power_hold_n_i,
             sel: {excitation_sel_1_i, excitation_sel_0_i},
             thermal: thermal_trip_i, uv: supply_undervolt_lock_i};
    step_rise = r_reg.s2.step & ~r_reg.step_prev;
    osc_rise = r_reg.osc2 & ~r_reg.osc_prev;
    inc = step_inc(res_e'(r_reg.s2.sel));
    mo_drive = (r_reg.pos == INIT_POS);
    // standby outranks enable-wait, which outranks reset
    if (!r_reg.s2.hold_n) begin
      op = OP_LOW_POWER_HOLD_N;
    end else if (!r_reg.s2.en) begin
      op = OP_WAIT;
    end else if (!r_reg.s2.rst_n) begin
      op = OP_INIT;
    end else begin
      op = OP_RUN;
    end
    status = 32'h0000_0000;
    status[ST_POS_LSB +: POS_W] = r_reg.pos;
    status[ST_RES_LSB +: 2] = r_reg.s2.sel;
    status[ST_MO_BIT] = step_monitor_in_i;
    status[ST_OP_LSB +: 2] = op;
    status[ST_BRIDGE_BIT] = r_reg.bridge;
    status[ST_CHOP_BIT] = r_reg.chop;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.step_prev = r_reg.s2.step;
    r_next.osc1 = osc_clock_i;
    r_next.osc2 = r_reg.osc1;
    r_next.osc_prev = r_reg.osc2;
    if (osc_rise) begin
      r_next.chop = ~r_reg.chop;
    end
    // sequencer keeps running in enable-wait and trips, only
    // standby and reset pin it to the initial vector
    if (!r_reg.s2.hold_n || !r_reg.s2.rst_n) begin
      r_next.pos = INIT_POS;
    end else if (step_rise && !r_reg.s2.dir) begin
      r_next.pos = POS_W'(r_reg.pos + inc);
    end else if (step_rise) begin
      r_next.pos = POS_W'(r_reg.pos - inc);
    end
    // trips drop the bridge like enable-wait without changing op, and clear by themselves
    case (op)
      OP_RUN, OP_INIT: begin
        r_next.bridge = ~r_reg.s2.thermal & ~r_reg.s2.uv & ~r_reg.kill;
      end
      default: begin
        r_next.bridge = 1'b0;
      end
    endcase
    // single-cycle ack, dropped the cycle after it is given
    r_next.ack = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    r_next.rdata = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      if (wb_adr_i == AW'(CTRL_OFS)) begin
        r_next.rdata[CTRL_KILL_BIT] = r_reg.kill;
        if (wb_we_i && wb_sel_i[0]) begin
          r_next.kill = wb_dat_i[CTRL_KILL_BIT];
        end
      end else if (wb_adr_i == AW'(STAT_OFS)) begin
        r_next.rdata = status;
      end
    end
  end

  // register, everything clears to standby-like values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.kill <= CTRL_KILL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bridge_drive_en_o = r_reg.bridge;
  assign seq_position_o = r_reg.pos;
  assign chopper_clk_o = r_reg.chop;
  assign step_monitor_out_o = 1'b0; // open drain only pulls low
  assign step_monitor_oe_n_o = ~mo_drive;
  assign wb_dat_o = r_reg.rdata;
  assign wb_ack_o = r_reg.ack;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_fwd;
    step_rise && r_reg.s2.hold_n && r_reg.s2.rst_n && !r_reg.s2.dir
      |=> r_reg.pos == POS_W'($past(r_reg.pos) + $past(inc));
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward step wrong");

  property p_back;
    step_rise && r_reg.s2.hold_n && r_reg.s2.rst_n && r_reg.s2.dir
      |=> r_reg.pos == POS_W'($past(r_reg.pos) - $past(inc));
  endproperty
  a_back: assert property (p_back) else $error("backward step wrong");

  property p_en_off;
    !r_reg.s2.en ##1 !r_reg.s2.en |-> !bridge_drive_en_o;
  endproperty
  a_en_off: assert property (p_en_off) else $error("bridge on while disabled");

  property p_low_power_hold_n;
    !r_reg.s2.hold_n |=> !bridge_drive_en_o && seq_position_o == INIT_POS;
  endproperty
  a_low_power_hold_n: assert property (p_low_power_hold_n) else $error("standby not honoured");

  property p_mo;
    (seq_position_o == INIT_POS) == !step_monitor_oe_n_o;
  endproperty
  a_mo: assert property (p_mo) else $error("monitor pin wrong");

  property p_chop;
    osc_rise |=> chopper_clk_o != $past(chopper_clk_o) ##1 $stable(chopper_clk_o);
  endproperty
  a_chop: assert property (p_chop) else $error("chopper divide wrong");

  property p_therm;
    r_reg.s2.thermal |=> !bridge_drive_en_o;
  endproperty
  a_therm: assert property (p_therm) else $error("bridge on in thermal trip");

  property p_therm_exit;
    $fell(r_reg.s2.thermal) && r_reg.s2.en && r_reg.s2.hold_n && !r_reg.s2.uv && !r_reg.kill
      |=> bridge_drive_en_o;
  endproperty
  a_therm_exit: assert property (p_therm_exit) else $error("no recovery after trip");

  property p_uv;
    r_reg.s2.uv |=> !bridge_drive_en_o;
  endproperty
  a_uv: assert property (p_uv) else $error("bridge on in undervoltage");

  property p_rst;
    !r_reg.s2.rst_n |=> seq_position_o == INIT_POS && !step_monitor_oe_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset did not hold initial");

  property p_hold;
    !step_rise && r_reg.s2.rst_n && r_reg.s2.hold_n |=> $stable(seq_position_o);
  endproperty
  a_hold: assert property (p_hold) else $error("moved without a step edge");

  property p_wait_step;
    step_rise && !r_reg.s2.en && r_reg.s2.hold_n && r_reg.s2.rst_n |=> !$stable(seq_position_o);
  endproperty
  a_wait_step: assert property (p_wait_step) else $error("no step in enable-wait");

  property p_full;
    step_rise && r_reg.s2.sel == 2'b00 && r_reg.s2.hold_n && r_reg.s2.rst_n && !r_reg.s2.dir
      |=> seq_position_o == POS_W'($past(seq_position_o) + 5'h08);
  endproperty
  a_full: assert property (p_full) else $error("full step size wrong");

  property p_one_edge;
    step_rise |=> !step_rise;
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("edge counted twice");

  property p_wrap;
    step_rise && r_reg.pos == 5'h1F && r_reg.s2.sel == 2'b11 && r_reg.s2.hold_n
      && r_reg.s2.rst_n && !r_reg.s2.dir |=> seq_position_o == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at cycle end");

  c_fwd: cover property (step_rise && r_reg.s2.hold_n && r_reg.s2.rst_n && !r_reg.s2.dir);
  c_back_wrap: cover property (step_rise && r_reg.pos == INIT_POS && r_reg.s2.dir && r_reg.s2.rst_n);
  c_trip: cover property ($fell(r_reg.s2.thermal) ##1 bridge_drive_en_o);
  c_wb_rd: cover property (wb_ack_o && !wb_we_i);

endmodule

// *** verification/step_host.sv ***
`timescale 1ns/1ns
// ------------------------------------------------
// host side: one step pulse per go request
// ------------------------------------------------
module step_host (
  // clock
  input wire logic clk_i,
  // request
  input wire logic go_i,
  input wire logic slow_i,
  // step pin and status
  output logic step_o,
  output logic busy_o
);
  // each level spans at least two clocks so the sync pair never drops it
  initial begin
    step_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        busy_o <= 1'b1;
        step_o <= 1'b1;
        repeat (slow_i ? 5 : 2) @(posedge clk_i);
        step_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// *** verification/stepper_microstep_control_tb.sv ***
`timescale 1ns/1ns
module stepper_microstep_control_tb;
  import stepper_pkg::*;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  logic clk_i, rst_i, go, slow, step, busy, bridge, chop, oe_n, mo_out, ack, last_chop;
  logic cyc, stb, we;
  logic [3:0] adr;
  logic [2:0] oc;
  logic [31:0] wdat, rdat, rd, lf;
  logic [4:0] pos, last_pos, exp_pos;
  logic [4:0] exp_q[$];
  pins_s p;
  int n_errors, n_compared, n_chop;
  // monitor wire with its pull-up
  wire mon = oe_n ? 1'b1 : mo_out;

  step_host u_host (.clk_i(clk_i), .go_i(go), .slow_i(slow), .step_o(step), .busy_o(busy));
  stepper_microstep_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .step_clock_in_i(step),
    .direction_select_i(p.dir), .seq_reset_n_i(p.rst_n), .enable_i(p.en), .low_power_hold_n_i(p.hold_n),
    .excitation_sel_0_i(p.sel[0]), .excitation_sel_1_i(p.sel[1]), .thermal_trip_i(p.thermal),
    .supply_undervolt_lock_i(p.uv), .osc_clock_i(oc[2]), .bridge_drive_en_o(bridge),
    .seq_position_o(pos), .chopper_clk_o(chop), .step_monitor_in_i(mon), .step_monitor_out_o(mo_out),
    .step_monitor_oe_n_o(oe_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  // ------------------------------------------------
  // clock, oscillator (4 clocks a level), watchdog
  // ------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) oc <= oc + 3'h1;
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [4:0] inc(input logic [1:0] s);
    return s == RES_FULL ? INC_FULL : s == RES_HALF ? INC_HALF : s == RES_QUARTER ? INC_QUARTER : INC_EIGHTH;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask
  // single classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no local limit: only the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // one step request; expected position noted before the pulse
  task automatic step1(input logic d, input logic mv);
    p.dir <= d;
    repeat (2) @(posedge clk_i);
    if (mv) begin
      exp_pos = d ? exp_pos - inc(p.sel) : exp_pos + inc(p.sel);
      exp_q.push_back(exp_pos);
    end
    lf = lfsr(lf);
    slow <= lf[0];
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (busy !== 1'b0);
    check(oe_n, exp_pos != 5'h00);
  endtask
  task automatic force_init;
    if (exp_pos != INIT_POS) exp_q.push_back(INIT_POS);
    exp_pos = INIT_POS;
  endtask
  task results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------
  // position watcher: every change takes the oldest note
  // ------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_i && pos !== last_pos) begin
      if (exp_q.size() == 0) check(pos, last_pos);
      else check(pos, exp_q.pop_front());
    end
    last_pos = pos;
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    {rst_i, lf, go, slow, oc, cyc, stb, we, adr, wdat} = {1'b1, 32'h7B13F8AE, 44'h0};
    p = '0;
    exp_pos = INIT_POS;
    last_pos = INIT_POS;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check(bridge, 1'b0);
    check(oe_n, 1'b0);
    check(mo_out, 1'b0);
    step1(1'b0, 1'b0);
    p.hold_n <= 1'b1;
    p.en <= 1'b1;
    settle();
    check(pos, INIT_POS);
    step1(1'b0, 1'b0);
    p.rst_n <= 1'b1;
    settle();
    // every resolution, first step backward so full mode wraps at once
    for (int i = 0; i < 4; i++) begin
      p.sel <= i[1:0];
      for (int j = 0; j < 6; j++) step1(j == 0 ? 1'b1 : lf[1], 1'b1);
    end
    wb(1'b0, STAT_OFS, 32'h0);
    check(rd[ST_OP_LSB +: 2], OP_RUN);
    check(rd[ST_POS_LSB +: 5], exp_pos);
    check(rd[ST_MO_BIT], exp_pos != INIT_POS);
    check(rd[ST_BRIDGE_BIT], 1'b1);
    p.en <= 1'b0;
    settle();
    check(bridge, 1'b0);
    step1(1'b0, 1'b1);
    p.en <= 1'b1;
    p.thermal <= 1'b1;
    settle();
    check(bridge, 1'b0);
    step1(1'b1, 1'b1);
    p.thermal <= 1'b0;
    settle();
    check(bridge, 1'b1);
    p.uv <= 1'b1;
    settle();
    check(bridge, 1'b0);
    step1(1'b0, 1'b1);
    p.uv <= 1'b0;
    n_chop = 0;
    last_chop = chop;
    repeat (80) begin
      @(posedge clk_i);
      if (chop !== last_chop) n_chop++;
      last_chop = chop;
    end
    check(n_chop >= 9 && n_chop <= 11, 1'b1);
    // software kill and an unmapped place
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    settle();
    check(bridge, 1'b0);
    wb(1'b1, 4'h8, 32'hFFFFFFFF);
    wb(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, CTRL_OFS, 32'h0);
    settle();
    check(bridge, 1'b1);
    force_init();
    p.rst_n <= 1'b0;
    settle();
    check(oe_n, 1'b0);
    p.rst_n <= 1'b1;
    settle();
    // eighth mode: wrap below zero and back over the top
    step1(1'b1, 1'b1);
    step1(1'b0, 1'b1);
    step1(1'b0, 1'b1);
    force_init();
    p.hold_n <= 1'b0;
    settle();
    check(bridge, 1'b0);
    step1(1'b1, 1'b0);
    check(exp_q.size(), 32'h0);
    results();
  end
endmodule
